// [rtl/bis_defines.svh]
// register offsets, field codes and sequence times for the ignition sequencer
`ifndef BIS_DEFINES_SVH
`define BIS_DEFINES_SVH
`define BIS_ADDR_W       4
`define BIS_OFS_CMD      4'h0
`define BIS_OFS_STATUS   4'h4
`define BIS_OFS_IRQ_STAT 4'h8
`define BIS_OFS_IRQ_MASK 4'hC
`define BIS_CMD_LO_RST   0
`define BIS_EV_W         4
`define BIS_EV_LOCKOUT   0
`define BIS_EV_RUN       1
`define BIS_EV_RECYCLE   2
`define BIS_EV_STANDBY   3
`define BIS_IGN_ONLY_S   8'h02
`define BIS_ESTAB_S      8'h06
`define BIS_STAB_S       8'h08
`define BIS_PREPURGE_S   8'h23
`define BIS_POSTPURGE_S  8'h23
`define BIS_FAN_PROVE_S  8'h78
`define BIS_MAX_RETRY    2'h3
`define BIS_FLT_NONE     8'h00
`define BIS_FLT_FAN      8'h01
`define BIS_FLT_IGN      8'h02
`define BIS_FLT_ILK      8'h03
`define BIS_FLT_JUMPER   8'h6E
`define BIS_CLK_HZ       100000000
`define BIS_HOURS_LIM    200
`endif

// [rtl/bis_pkg.sv]
// types shared by the ignition sequencer
package bis_pkg;
  typedef enum logic [2:0] {
    BIS_STANDBY,
    BIS_FAN_WAIT,
    BIS_PREPURGE,
    BIS_ESTAB,
    BIS_STAB,
    BIS_RUN,
    BIS_POSTPURGE,
    BIS_LOCKOUT
  } bis_state_t;
  // plant contacts, high = closed / present
  typedef struct packed {
    logic ctl;
    logic ilk;
    logic cps;
    logic flame;
    logic pfs;
    logic hfs;
  } bis_plant_t;
  // jumper inputs, high = clipped
  typedef struct packed {
    logic modulation_option_jumper;
    logic flame_amp_option_jumper;
    logic retry_option_jumper;
  } bis_jumper_t;
endpackage

// [rtl/bis_sequencer.sv]
// boiler ignition sequencer: purge, ignition trials, run and postpurge
//
// The strobed register port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
// Operation
// - ignition alone two seconds before fuel valve
// - amp off: valve four s, pressure by six
// - proving failure: three recycles or lockout
// - eight second stabilization, pressure loss fails
// - amp on: pressure, flame, fan open by six
// - amp on stabilization: pressure, flame, fan checks
// - fan output off during run
// - leave run on control, interlock, pressure, flame if amp on
// - 35 second postpurge with fan on
// - control drop in trials or run: postpurge
// - postpurge: fuel valve and spark off, timer waits fan switch
// - postpurge done returns to standby
// - three jumpers, intact is default
// - jumper change after 200 hours locks out
// - 35 second prepurge while inputs correct
// - fan switches must close within 120 s
`include "bis_defines.svh"
module bis_sequencer
  import bis_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = `BIS_CLK_HZ,
  parameter int unsigned HOURS_LIM_S = `BIS_HOURS_LIM * 3600
) (
  input  wire logic                   ref_clk_i,
  input  wire logic                   nrst_i,
  input  wire bis_plant_t             plant_i,
  input  wire bis_jumper_t            jumper_i,
  input  wire logic [`BIS_ADDR_W-1:0] addr_i,
  input  wire logic [31:0]            wdata_i,
  input  wire logic                   wr_i,
  input  wire logic                   rd_i,
  output logic      [31:0]            rdata_o,
  output logic                        fan_o,
  output logic                        ign_o,
  output logic                        valve_o,
  output logic                        alarm_o,
  output logic                        modulate_o,
  output logic                        irq_o
);

  bis_plant_t             pl_m_q;
  bis_plant_t             pl_q;
  bis_jumper_t            jp_m_q;
  bis_jumper_t            jp_q;
  bis_jumper_t            cfg_q;
  logic                   cfg_ok_q;
  logic [31:0]            div_q;
  logic                   tick_q;
  logic [31:0]            op_sec_q;
  logic                   hours_up;
  bis_state_t             st_q;
  bis_state_t             st_d;
  logic [7:0]             sec_q;
  logic [1:0]             retry_q;
  logic [7:0]             fault_q;
  logic [7:0]             fault_d;
  logic [`BIS_EV_W-1:0]   ev;
  logic [`BIS_EV_W-1:0]   irq_stat_q;
  logic [`BIS_EV_W-1:0]   irq_mask_q;
  logic                   lo_rst;
  logic                   amp_on;
  logic                   retry_ok;
  logic                   jp_change;
  logic                   done_at;
  logic [7:0]             limit;
  logic                   prove_ok;
  logic                   stab_bad;
  logic                   fail;
  logic                   restart;

  // two flops on every plant and jumper pin before any logic looks at it
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pl_m_q <= '0;
      pl_q   <= '0;
      jp_m_q <= '0;
      jp_q   <= '0;
    end else begin
      pl_m_q <= plant_i;
      pl_q   <= pl_m_q;
      jp_m_q <= jumper_i;
      jp_q   <= jp_m_q;
    end
  end

  // a timed period starts on a state change, and again each cycle that postpurge air is not yet proven
  assign restart = (st_d != st_q) || (st_q == BIS_POSTPURGE && !pl_q.pfs);

  // one second tick from the system clock; the divider restarts with each
  // timed period, so that no period falls short by a part of a second
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      div_q  <= '0;
      tick_q <= 1'b0;
    end else if (restart) begin
      div_q  <= 32'h1;
      tick_q <= 1'b0;
    end else if (div_q == TICK_CYCLES - 1) begin
      div_q  <= '0;
      tick_q <= 1'b1;
    end else begin
      div_q  <= div_q + 32'h1;
      tick_q <= 1'b0;
    end
  end

  // accumulated operating seconds, saturating once the limit is passed
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      op_sec_q <= '0;
    end else if (tick_q && !hours_up) begin
      op_sec_q <= op_sec_q + 32'h1;
    end
  end
  assign hours_up = (op_sec_q > HOURS_LIM_S);

  // jumper setting is caught after reset, once the pins have settled
  // through the synchroniser; early changes are simply adopted
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cfg_q    <= '0;
      cfg_ok_q <= 1'b0;
    end else if (!cfg_ok_q || (jp_change && !hours_up)) begin
      cfg_q    <= jp_q;
      cfg_ok_q <= tick_q | cfg_ok_q;
    end
  end
  assign jp_change = cfg_ok_q && (jp_q != cfg_q);

  // option decode: clipped jumper enables flame amp and modulation, but disables retries
  assign amp_on   = cfg_q.flame_amp_option_jumper;
  assign retry_ok = !cfg_q.retry_option_jumper && (retry_q < `BIS_MAX_RETRY);

  // lockout reset command from software
  assign lo_rst = wr_i && (addr_i == `BIS_OFS_CMD) && wdata_i[`BIS_CMD_LO_RST];

  // end of the current timed period
  always_comb begin
    unique case (st_q)
      BIS_FAN_WAIT:  limit = `BIS_FAN_PROVE_S;
      BIS_PREPURGE:  limit = `BIS_PREPURGE_S;
      BIS_ESTAB:     limit = `BIS_ESTAB_S;
      BIS_STAB:      limit = `BIS_STAB_S;
      BIS_POSTPURGE: limit = `BIS_POSTPURGE_S;
      default:       limit = 8'hFF;
    endcase
  end
  assign done_at = tick_q && (sec_q == limit - 8'h01);

  // proving at close of establishing, and faults during stabilization
  assign prove_ok = pl_q.cps && (!amp_on || (pl_q.flame && !pl_q.pfs));
  assign stab_bad = !pl_q.cps || (amp_on && (!pl_q.flame || pl_q.pfs));
  assign fail     = (st_q == BIS_ESTAB && done_at && !prove_ok)
                 || (st_q == BIS_STAB && stab_bad);

  // sequence transitions
  always_comb begin
    st_d    = st_q;
    fault_d = fault_q;
    unique case (st_q)
      BIS_STANDBY: begin
        if (pl_q.ctl && pl_q.ilk) begin
          st_d = BIS_FAN_WAIT;
        end
      end
      BIS_FAN_WAIT: begin
        if (!pl_q.ctl) begin
          st_d = BIS_STANDBY;
        end else if (pl_q.pfs && pl_q.hfs) begin
          st_d = BIS_PREPURGE;
        end else if (done_at) begin
          st_d    = BIS_LOCKOUT;
          fault_d = `BIS_FLT_FAN;
        end
      end
      BIS_PREPURGE: begin
        if (!pl_q.ctl) begin
          st_d = BIS_STANDBY;
        end else if (!pl_q.ilk) begin
          st_d    = BIS_LOCKOUT;
          fault_d = `BIS_FLT_ILK;
        end else if (!pl_q.pfs || !pl_q.hfs) begin
          st_d = BIS_FAN_WAIT;
        end else if (done_at) begin
          st_d = BIS_ESTAB;
        end
      end
      BIS_ESTAB, BIS_STAB: begin
        if (!pl_q.ctl) begin
          st_d = BIS_POSTPURGE;
        end else if (fail && retry_ok) begin
          st_d = BIS_FAN_WAIT;
        end else if (fail) begin
          st_d    = BIS_LOCKOUT;
          fault_d = `BIS_FLT_IGN;
        end else if (done_at) begin
          st_d = (st_q == BIS_ESTAB) ? BIS_STAB : BIS_RUN;
        end
      end
      BIS_RUN: begin
        if (!pl_q.ctl || !pl_q.ilk || !pl_q.cps || (amp_on && !pl_q.flame)) begin
          st_d = BIS_POSTPURGE;
        end
      end
      BIS_POSTPURGE: begin
        if (done_at) begin
          st_d = BIS_STANDBY;
        end
      end
      BIS_LOCKOUT: begin
        if (lo_rst) begin
          st_d    = BIS_STANDBY;
          fault_d = `BIS_FLT_NONE;
        end
      end
    endcase
    // a late jumper change overrides every other path except the lockout reset
    if (jp_change && hours_up && st_q != BIS_LOCKOUT) begin
      st_d    = BIS_LOCKOUT;
      fault_d = `BIS_FLT_JUMPER;
    end
  end

  // state and fault code registers
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st_q    <= BIS_STANDBY;
      fault_q <= `BIS_FLT_NONE;
    end else begin
      st_q    <= st_d;
      fault_q <= fault_d;
    end
  end

  // seconds within the period; postpurge holds at zero until the fan
  // switch proves air flow, so a dead fan cannot fake a purge
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sec_q <= '0;
    end else if (st_d != st_q) begin
      sec_q <= '0;
    end else if (st_q == BIS_POSTPURGE && !pl_q.pfs) begin
      sec_q <= '0;
    end else if (tick_q && sec_q != 8'hFF) begin
      sec_q <= sec_q + 8'h01;
    end
  end

  // ignition retry count
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      retry_q <= '0;
    end else if (st_d == BIS_RUN && st_q != BIS_RUN) begin
      retry_q <= '0;
    end else if (st_q == BIS_LOCKOUT && lo_rst) begin
      retry_q <= '0;
    end else if (fail && retry_ok && pl_q.ctl) begin
      retry_q <= retry_q + 2'h1;
    end
  end

  // load outputs, all straight from flops
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      fan_o      <= 1'b0;
      ign_o      <= 1'b0;
      valve_o    <= 1'b0;
      alarm_o    <= 1'b0;
      modulate_o <= 1'b0;
    end else begin
      fan_o      <= (st_d != BIS_STANDBY) && (st_d != BIS_RUN)
                 && (st_d != BIS_LOCKOUT);
      ign_o      <= (st_d == BIS_ESTAB) && (sec_q < `BIS_IGN_ONLY_S)
                 && (st_q == BIS_ESTAB || st_d != st_q);
      valve_o    <= ((st_d == BIS_ESTAB) && (st_q == BIS_ESTAB)
                 && (sec_q >= `BIS_IGN_ONLY_S))
                 || (st_d == BIS_STAB) || (st_d == BIS_RUN);
      alarm_o    <= (st_d == BIS_LOCKOUT);
      modulate_o <= (st_d == BIS_RUN) && cfg_q.modulation_option_jumper;
    end
  end

  // sequence events for the interrupt status
  always_comb begin
    ev = '0;
    ev[`BIS_EV_LOCKOUT] = (st_d == BIS_LOCKOUT) && (st_q != BIS_LOCKOUT);
    ev[`BIS_EV_RUN]     = (st_d == BIS_RUN) && (st_q != BIS_RUN);
    ev[`BIS_EV_RECYCLE] = (st_d == BIS_FAN_WAIT) && (st_q == BIS_ESTAB || st_q == BIS_STAB);
    ev[`BIS_EV_STANDBY] = (st_d == BIS_STANDBY) && (st_q == BIS_POSTPURGE);
  end

  // sticky status, cleared by a read; a new event in the read cycle wins
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      irq_stat_q <= '0;
    end else if (rd_i && addr_i == `BIS_OFS_IRQ_STAT) begin
      irq_stat_q <= ev;
    end else begin
      irq_stat_q <= irq_stat_q | ev;
    end
  end

  // interrupt mask register
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      irq_mask_q <= '0;
    end else if (wr_i && addr_i == `BIS_OFS_IRQ_MASK) begin
      irq_mask_q <= wdata_i[`BIS_EV_W-1:0];
    end
  end

  // level interrupt, registered from next status so it tracks it exactly
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      irq_o <= 1'b0;
    end else if (rd_i && addr_i == `BIS_OFS_IRQ_STAT) begin
      irq_o <= |(ev & irq_mask_q);
    end else if (wr_i && addr_i == `BIS_OFS_IRQ_MASK) begin
      irq_o <= |((irq_stat_q | ev) & wdata_i[`BIS_EV_W-1:0]);
    end else begin
      irq_o <= |((irq_stat_q | ev) & irq_mask_q);
    end
  end

  // read data, valid the cycle after the strobe only
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rdata_o <= '0;
    end else if (rd_i) begin
      unique case (addr_i)
        `BIS_OFS_STATUS:
          rdata_o <= {1'b0, hours_up, jp_q, cfg_q, fault_q, 6'h00, retry_q,
                      5'h00, st_q};
        `BIS_OFS_IRQ_STAT: rdata_o <= {28'h0000000, irq_stat_q};
        `BIS_OFS_IRQ_MASK: rdata_o <= {28'h0000000, irq_mask_q};
        default:           rdata_o <= '0;
      endcase
    end else begin
      rdata_o <= '0;
    end
  end

endmodule

// [sim/bis_seq_assertions.sv]
// concurrent checks on the ignition sequencer ports
`timescale 1ns/1ps
module bis_seq_checker
  import bis_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = 10
) (
  input wire logic        ref_clk_i,
  input wire logic        nrst_i,
  input wire logic        rd_i,
  input wire logic        wr_i,
  input wire logic [31:0] rdata_o,
  input wire logic        fan_o,
  input wire logic        ign_o,
  input wire logic        valve_o,
  input wire logic        alarm_o
);
  logic [31:0] ign_q;
  logic [31:0] pp_cnt_q;
  logic        fan_q;
  logic        valve_q;
  logic        pp_q;
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!nrst_i);
  // spans of seconds are counted in clocks, too long for a repetition
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ign_q    <= '0;
      pp_cnt_q <= '0;
      fan_q    <= 1'b0;
      valve_q  <= 1'b0;
      pp_q     <= 1'b0;
    end else begin
      ign_q    <= ign_o ? ign_q + 32'h1 : '0;
      pp_cnt_q <= fan_o ? pp_cnt_q + 32'h1 : '0;
      fan_q    <= fan_o;
      valve_q  <= valve_o;
      // postpurge is the only fan start that follows a lit burner
      if (fan_o && !fan_q && valve_q) begin
        pp_q <= 1'b1;
      end else if (!fan_o) begin
        pp_q <= 1'b0;
      end
    end
  end
  a_ign_alone: assert property (ign_o |-> fan_o && !valve_o)
    else $error("ignition overlaps fuel valve");
  a_valve_after_ign: assert property ($rose(valve_o) |-> $past(ign_o))
    else $error("fuel valve opened without spark first");
  a_ign_two_sec: assert property ($fell(ign_o) && valve_o |-> ign_q == 2 * TICK_CYCLES)
    else $error("spark alone not two seconds");
  a_run_fan_off: assert property (valve_o && !fan_o |=> !fan_o || !valve_o)
    else $error("fan on while burner runs");
  a_pp_outputs_off: assert property ($rose(fan_o) && $past(valve_o) |-> !valve_o && !ign_o)
    else $error("fuel or spark on in postpurge");
  a_pp_length: assert property (pp_q && !fan_o |-> pp_cnt_q >= 35 * TICK_CYCLES)
    else $error("postpurge shorter than 35 seconds");
  a_alarm_safe: assert property (alarm_o |-> !fan_o && !ign_o && !valve_o)
    else $error("load energized in lockout");
  a_alarm_hold: assert property (alarm_o && !wr_i |=> alarm_o)
    else $error("lockout left without command");
  a_rdata_idle: assert property (!$past(rd_i) |-> rdata_o == 32'h0)
    else $error("read data outside read slot");
  c_run_entry: cover property ($fell(fan_o) && valve_o);
  c_lockout: cover property ($rose(alarm_o));
  c_pp_done: cover property (pp_q && !fan_o);
endmodule

bind bis_sequencer bis_seq_checker #(.TICK_CYCLES(TICK_CYCLES)) u_chk (
  .ref_clk_i(ref_clk_i),
  .nrst_i   (nrst_i),
  .rd_i     (rd_i),
  .wr_i     (wr_i),
  .rdata_o  (rdata_o),
  .fan_o    (fan_o),
  .ign_o    (ign_o),
  .valve_o  (valve_o),
  .alarm_o  (alarm_o)
);

// [sim/bis_plant_model.sv]
// behavioural plant: airflow switches, combustion pressure and flame
`timescale 1ns/1ps
module bis_plant_model
  import bis_pkg::*;
(
  input  wire logic  ctl_i,
  input  wire logic  ilk_i,
  input  wire logic  fan_i,
  input  wire logic  valve_i,
  input  wire logic  cps_fail_i,
  input  wire logic  flame_fail_i,
  input  wire logic  air_fail_i,
  output bis_plant_t plant_o
);
  // firing pulls the purge switch open, so it proves only on air alone
  assign plant_o = {ctl_i, ilk_i, valve_i & ~cps_fail_i, valve_i & ~flame_fail_i,
                    fan_i & ~valve_i & ~air_fail_i, fan_i & ~air_fail_i};
endmodule

// [sim/boiler_ignition_sequencer_bench.sv]
// self-checking bench for the ignition sequencer with a plant model
`timescale 1ns/1ps
module boiler_ignition_sequencer_bench;
  import bis_pkg::*;
`include "bis_defines.svh"
  logic        ref_clk_i = 1'b0;
  logic        nrst_i = 1'b0;
  logic        wr_i = 1'b0;
  logic        rd_i = 1'b0;
  logic        ctl = 1'b0;
  logic        ilk = 1'b1;
  logic        cps_f = 1'b0;
  logic        fl_f = 1'b0;
  logic        air_f = 1'b0;
  bis_jumper_t jumper = '0;
  bis_plant_t  plant;
  logic [3:0]  addr = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic [31:0] rdata;
  logic [31:0] d;
  logic        fan, ign, valve, alarm, irq, modulate;
  int          n_fail = 0;
  int          checked = 0;
  int          seed = 75;
  int          cyc = 0;
  time         t0;
  localparam logic [31:0] MSK = 32'h07FF_0307;
  bis_plant_model u_plant (.ctl_i(ctl), .ilk_i(ilk), .fan_i(fan), .valve_i(valve),
    .cps_fail_i(cps_f), .flame_fail_i(fl_f), .air_fail_i(air_f), .plant_o(plant));
  bis_sequencer #(.TICK_CYCLES(10), .HOURS_LIM_S(3)) DUT (.ref_clk_i(ref_clk_i),
    .nrst_i(nrst_i), .plant_i(plant), .jumper_i(jumper), .addr_i(addr), .wdata_i(wdata),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata), .fan_o(fan), .ign_o(ign), .valve_o(valve),
    .alarm_o(alarm), .modulate_o(modulate), .irq_o(irq));
  always #5 ref_clk_i = ~ref_clk_i;
  // expected status fields: cfg, fault, retries, state
  function automatic logic [31:0] st(input logic [2:0] s, input logic [1:0] r,
                                     input logic [7:0] f, input logic [2:0] c);
    return {5'h0, c, f, 6'h0, r, 5'h0, s};
  endfunction
  task automatic tally_and_finish();
    $display("checked=%0d n_fail=%0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge ref_clk_i);
    addr  <= a;
    wdata <= v;
    wr_i  <= 1'b1;
    @(posedge ref_clk_i);
    wr_i  <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] v);
    @(posedge ref_clk_i);
    addr <= a;
    rd_i <= 1'b1;
    @(posedge ref_clk_i);
    rd_i <= 1'b0;
    #1 v = rdata;
  endtask
  // poll the state field under a bounded count of reads
  task automatic wait_st(input logic [2:0] s);
    for (int i = 0; i < 1000; i++) begin
      rd(`BIS_OFS_STATUS, d);
      if (d[2:0] === s) return;
    end
    cmp({29'h0, d[2:0]}, {29'h0, s});
  endtask
  // hang guard well above the longest expected sequence
  always @(posedge ref_clk_i) begin
    cyc++;
    if (cyc > 30000) begin
      n_fail++;
      tally_and_finish();
    end
  end
  initial begin
    repeat (6) @(posedge ref_clk_i);
    nrst_i <= 1'b1;
    rd(`BIS_OFS_STATUS, d);
    cmp(d & MSK, st(0, 0, 0, 0));
    wr(4'h2, $random(seed));
    rd(4'h2, d);
    cmp(d, 32'h0);
    wr(`BIS_OFS_IRQ_MASK, 32'hF);
    repeat (($random(seed) & 15) + 1) @(posedge ref_clk_i);
    ctl <= 1'b1;
    wait_st(BIS_RUN);
    cmp({31'h0, fan}, 32'h0);
    cmp({31'h0, modulate}, 32'h0);
    rd(`BIS_OFS_IRQ_STAT, d);
    cmp(d & 32'h2, 32'h2);
    @(posedge ref_clk_i) ctl <= 1'b0;
    wait_st(BIS_POSTPURGE);
    cmp({29'h0, valve, ign, fan}, 32'h1);
    t0 = $time;
    wait_st(BIS_STANDBY);
    cmp({31'h0, ($time - t0) >= 350 * 10}, 32'h1);
    rd(`BIS_OFS_IRQ_STAT, d);
    cmp(d & 32'h8, 32'h8);
    // control drop during ignition trials goes straight to postpurge
    @(posedge ref_clk_i) ctl <= 1'b1;
    wait_st(BIS_ESTAB);
    @(posedge ref_clk_i) ctl <= 1'b0;
    wait_st(BIS_POSTPURGE);
    cmp({29'h0, valve, ign, fan}, 32'h1);
    wait_st(BIS_STANDBY);
    // pressure lost in stabilization, then failures in establishing
    wr(`BIS_OFS_IRQ_MASK, 32'h0);
    @(posedge ref_clk_i) ctl <= 1'b1;
    wait_st(BIS_STAB);
    @(posedge ref_clk_i) cps_f <= 1'b1;
    for (int r = 1; r <= 3; r++) begin
      wait_st(BIS_PREPURGE);
      rd(`BIS_OFS_STATUS, d);
      cmp(d & MSK, st(BIS_PREPURGE, r[1:0], 0, 0));
      if (r < 3) wait_st(BIS_ESTAB);
    end
    wait_st(BIS_LOCKOUT);
    rd(`BIS_OFS_STATUS, d);
    cmp(d & MSK, st(BIS_LOCKOUT, 3, `BIS_FLT_IGN, 0));
    cmp({30'h0, alarm, irq}, 32'h2);
    wr(`BIS_OFS_IRQ_MASK, 32'hF);
    repeat (2) @(posedge ref_clk_i);
    #1 cmp({31'h0, irq}, 32'h1);
    rd(`BIS_OFS_IRQ_STAT, d);
    cmp(d & 32'h5, 32'h5);
    repeat (2) @(posedge ref_clk_i);
    #1 cmp({31'h0, irq}, 32'h0);
    @(posedge ref_clk_i) ctl <= 1'b0;
    cps_f <= 1'b0;
    wr(`BIS_OFS_CMD, 32'h1);
    wait_st(BIS_STANDBY);
    rd(`BIS_OFS_STATUS, d);
    cmp(d & MSK, st(BIS_STANDBY, 0, 0, 0));
    // air switches never prove: lockout once the proving time runs out
    @(posedge ref_clk_i) air_f <= 1'b1;
    ctl <= 1'b1;
    wait_st(BIS_LOCKOUT);
    rd(`BIS_OFS_STATUS, d);
    cmp(d & MSK, st(BIS_LOCKOUT, 0, `BIS_FLT_FAN, 0));
    @(posedge ref_clk_i) ctl <= 1'b0;
    air_f <= 1'b0;
    wr(`BIS_OFS_CMD, 32'h1);
    wait_st(BIS_STANDBY);
    @(posedge ref_clk_i) jumper <= 3'b001;
    wait_st(BIS_LOCKOUT);
    rd(`BIS_OFS_STATUS, d);
    cmp(d & 32'h00FF_0007, st(BIS_LOCKOUT, 0, `BIS_FLT_JUMPER, 0));
    // second reset with flame supervision and lockout-on-failure
    @(posedge ref_clk_i) nrst_i <= 1'b0;
    jumper <= 3'b111;
    repeat (6) @(posedge ref_clk_i);
    nrst_i <= 1'b1;
    ctl <= 1'b1;
    wait_st(BIS_RUN);
    rd(`BIS_OFS_STATUS, d);
    cmp(d & MSK, st(BIS_RUN, 0, 0, 3'b111));
    cmp({31'h0, modulate}, 32'h1);
    @(posedge ref_clk_i) fl_f <= 1'b1;
    wait_st(BIS_POSTPURGE);
    wait_st(BIS_LOCKOUT);
    rd(`BIS_OFS_STATUS, d);
    cmp(d & MSK, st(BIS_LOCKOUT, 0, `BIS_FLT_IGN, 3'b111));
    tally_and_finish();
  end
endmodule
